// *** test/cfdp_testbench.sv ***
// self-checking bench for the flag datapath and dual data pointer unit
// assumes cfdp_core is compiled with its package and header before this file
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // stimulus and observation
    // ----------------------------------------------------------------
    logic clk_sys;
    logic rst;
    logic op_valid;
    cfdp_pkg::cfdp_op_type op_code;
    logic [7:0] acc_in;
    logic [7:0] b_in;
    logic cy_in;
    logic aux_carry_flag;
    logic overflow_flag;
    logic [7:0] cmp_src;
    logic [7:0] cmp_dst;
    logic [7:0] sfr_addr;
    logic sfr_wr_en;
    logic sfr_rd_en;
    logic [7:0] sfr_wdata;
    logic ptr_load_en;
    logic [15:0] ptr_load_value;
    logic ptr_move_en;
    logic ptr_move_via_active_data_pointer;
    logic [7:0] acc_out_ff;
    logic [7:0] b_out_ff;
    logic cy_out_ff;
    logic ov_out_ff;
    logic result_valid_ff;
    logic branch_take_ff;
    logic [7:0] sfr_rdata_ff;
    logic [15:0] active_data_pointer_ff;
    int num_errors = 0;
    int n_tests = 0;
    logic [7:0] ctrl;
    logic [8:0] da_sum;
    logic [9:0] da_tab [0:5] = '{10'h00A, 10'h09A, 10'h245, 10'h045, 10'h199, 10'h123};
    logic [15:0] starts [0:3] = '{16'h1234, 16'hFFFF, 16'h0000, 16'h00A5};
    logic [15:0] exps [0:3] = '{16'h1234, 16'h0000, 16'hFFFF, 16'h00A4};

    cfdp_core cfdp_core_inst (
        .clk_sys(clk_sys), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .acc_in(acc_in), .b_in(b_in), .cy_in(cy_in), .aux_carry_flag(aux_carry_flag),
        .overflow_flag(overflow_flag), .cmp_src(cmp_src), .cmp_dst(cmp_dst),
        .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en),
        .sfr_wdata(sfr_wdata), .ptr_load_en(ptr_load_en), .ptr_load_value(ptr_load_value),
        .ptr_move_en(ptr_move_en), .ptr_move_via_active_data_pointer(ptr_move_via_active_data_pointer),
        .acc_out_ff(acc_out_ff), .b_out_ff(b_out_ff), .cy_out_ff(cy_out_ff),
        .ov_out_ff(ov_out_ff), .result_valid_ff(result_valid_ff),
        .branch_take_ff(branch_take_ff), .sfr_rdata_ff(sfr_rdata_ff),
        .active_data_pointer_ff(active_data_pointer_ff)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // access tasks, all driven on the falling edge
    // ----------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ef packs carry, overflow, result valid, branch taken
    task automatic op_chk(input cfdp_pkg::cfdp_op_type c, input logic [7:0] a,
                          input logic [7:0] bv, input logic cy, input logic ac,
                          input logic ov, input logic [7:0] s, input logic [7:0] d,
                          input logic [7:0] ea, input logic [7:0] eb, input logic [3:0] ef);
        @(negedge clk_sys);
        op_code = c;
        acc_in = a;
        b_in = bv;
        cy_in = cy;
        aux_carry_flag = ac;
        overflow_flag = ov;
        cmp_src = s;
        cmp_dst = d;
        op_valid = 1'b1;
        @(negedge clk_sys);
        op_valid = 1'b0;
        chk({acc_out_ff, b_out_ff, 4'h0, cy_out_ff, ov_out_ff, result_valid_ff,
             branch_take_ff}, {ea, eb, 4'h0, ef});
    endtask

    task automatic sfr_wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        sfr_addr = addr;
        sfr_wdata = data;
        sfr_wr_en = 1'b1;
        @(negedge clk_sys);
        sfr_wr_en = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clk_sys);
        sfr_addr = addr;
        sfr_rd_en = 1'b1;
        @(negedge clk_sys);
        sfr_rd_en = 1'b0;
        chk({16'h0000, sfr_rdata_ff}, {16'h0000, exp});
    endtask

    // extra idle cycle so the pointer output has settled either way
    task automatic ptr_act(input logic ld, input logic mv, input logic via,
                           input logic [15:0] v);
        @(negedge clk_sys);
        ptr_load_en = ld;
        ptr_move_en = mv;
        ptr_move_via_active_data_pointer = via;
        ptr_load_value = v;
        @(negedge clk_sys);
        ptr_load_en = 1'b0;
        ptr_move_en = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic ptr_chk(input logic [15:0] exp);
        chk({8'h00, active_data_pointer_ff}, {8'h00, exp});
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // watchdog, the full run needs well under a thousand cycles
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        test_done();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        op_valid = 1'b0;
        op_code = cfdp_pkg::CFDP_OP_NONE;
        {acc_in, b_in, cmp_src, cmp_dst, sfr_addr, sfr_wdata} = '0;
        {cy_in, aux_carry_flag, overflow_flag, sfr_wr_en, sfr_rd_en} = '0;
        {ptr_load_en, ptr_move_en, ptr_move_via_active_data_pointer} = '0;
        ptr_load_value = 16'h0000;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        ptr_chk(16'h0000);
        rd_chk(8'hA7, 8'h00);
        // divide: carry cleared even when set before, overflow set only by a zero divisor, which keeps operands
        op_chk(cfdp_pkg::CFDP_OP_DIV, 8'h07, 8'h02, 1, 0, 1, 0, 0, 8'h03, 8'h01, 4'h2);
        op_chk(cfdp_pkg::CFDP_OP_DIV, 8'hFF, 8'h10, 1, 0, 1, 0, 0, 8'h0F, 8'h0F, 4'h2);
        op_chk(cfdp_pkg::CFDP_OP_DIV, 8'hFF, 8'hFF, 0, 0, 0, 0, 0, 8'h01, 8'h00, 4'h2);
        op_chk(cfdp_pkg::CFDP_OP_DIV, 8'h05, 8'h00, 1, 0, 0, 0, 0, 8'h05, 8'h00, 4'h6);
        // decimal adjust table holds {carry, aux carry, acc}
        for (int i = 0; i < 6; i++) begin
            da_sum = {1'b0, da_tab[i][7:0]};
            if (da_tab[i][8] || da_tab[i][3:0] > 4'h9) begin
                da_sum = da_sum + 9'h006;
            end
            if (da_tab[i][9] || da_tab[i][8] || da_tab[i][3:0] > 4'h9) begin
                da_sum = da_sum + 9'h060;
            end
            op_chk(cfdp_pkg::CFDP_OP_DA, da_tab[i][7:0], 8'h5A, da_tab[i][9], da_tab[i][8], 1,
                   0, 0, da_sum[7:0], 8'h5A, {da_sum > 9'h099, 3'b110});
        end
        op_chk(cfdp_pkg::CFDP_OP_RRC, 8'h81, 8'h3C, 0, 0, 0, 0, 0, 8'h40, 8'h3C, 4'hA);
        op_chk(cfdp_pkg::CFDP_OP_RRC, 8'h02, 8'h3C, 1, 0, 0, 0, 0, 8'h81, 8'h3C, 4'h2);
        op_chk(cfdp_pkg::CFDP_OP_RLC, 8'h81, 8'h3C, 0, 0, 1, 0, 0, 8'h02, 8'h3C, 4'hE);
        op_chk(cfdp_pkg::CFDP_OP_RLC, 8'h40, 8'h3C, 1, 0, 0, 0, 0, 8'h81, 8'h3C, 4'h2);
        op_chk(cfdp_pkg::CFDP_OP_CJNE, 8'hC3, 8'h11, 0, 0, 0, 8'h50, 8'h20, 8'hC3, 8'h11, 4'hB);
        op_chk(cfdp_pkg::CFDP_OP_CJNE, 8'hC3, 8'h11, 1, 0, 0, 8'h20, 8'h50, 8'hC3, 8'h11, 4'h3);
        op_chk(cfdp_pkg::CFDP_OP_CJNE, 8'hC3, 8'h11, 1, 0, 0, 8'h33, 8'h33, 8'hC3, 8'h11, 4'h2);
        // an idle opcode must not raise a result; earlier outputs hold
        op_chk(cfdp_pkg::CFDP_OP_NONE, 8'h77, 8'h66, 1, 1, 1, 0, 1, 8'hC3, 8'h11, 4'h0);
        // every mode on both pointers, then a move not through the pointer
        for (int sel = 0; sel < 2; sel++) begin
            for (int m = 0; m < 4; m++) begin
                ctrl = (sel == 1) ? {2'b00, m[1:0], 2'b00, 2'b01} : {4'h0, m[1:0], 2'b00};
                sfr_wr(8'hA7, ctrl);
                rd_chk(8'hA7, ctrl);
                ptr_act(1, 0, 0, starts[m]);
                ptr_act(0, 1, 1, 16'h0000);
                ptr_chk(exps[m]);
                ptr_act(0, 1, 0, 16'h0000);
                ptr_chk(exps[m]);
            end
        end
        // automatic swap walk with both pointers incrementing
        sfr_wr(8'hA7, 8'h00);
        ptr_act(1, 0, 0, 16'h0000);
        sfr_wr(8'hA7, 8'h55);
        ptr_act(1, 0, 0, 16'hD000);
        ptr_chk(16'hD000);
        ptr_act(0, 1, 1, 16'h0000);
        ptr_chk(16'h0000);
        ptr_act(0, 1, 1, 16'h0000);
        ptr_chk(16'hD001);
        ptr_act(0, 1, 0, 16'h0000);
        ptr_chk(16'h0001);
        sfr_wr(8'hA7, 8'h14);
        ptr_chk(16'h0001);
        ptr_act(0, 1, 1, 16'h0000);
        ptr_chk(16'h0002);
        // unimplemented bits and a foreign address
        sfr_wr(8'hA7, 8'hFF);
        rd_chk(8'hA7, 8'h7D);
        sfr_wr(8'hA6, 8'h00);
        rd_chk(8'hA7, 8'h7D);
        rd_chk(8'hA6, 8'h00);
        test_done();
    end
endmodule

// *** verilog/cfdp_arith.sv ***
// combinational results for divide, decimal adjust, rotates and compare
// assumes operands are stable for the cycle in which op is presented
`include "cfdp_regs.svh"

module cfdp_arith (
    input wire cfdp_pkg::cfdp_op_type op,
    input wire logic [7:0] acc,
    input wire logic [7:0] b,
    input wire logic cy,
    input wire logic ac,
    input wire logic ov,
    input wire logic [7:0] src,
    input wire logic [7:0] dst,
    output logic [7:0] res_acc,
    output logic [7:0] res_b,
    output logic res_cy,
    output logic res_ov,
    output logic res_take
);

    // ----------------------------------------------------------------
    // decimal adjust
    // ----------------------------------------------------------------
    logic lo_adj;
    logic [8:0] sum_lo;
    logic [8:0] sum_hi;

    always_comb begin
        lo_adj = ac || (acc[3:0] > `CFDP_DA_LO_LIMIT);
        sum_lo = {1'b0, acc} + (lo_adj ? `CFDP_DA_LO_ADJ : 9'h000);
        sum_hi = sum_lo + ((cy || lo_adj) ? `CFDP_DA_HI_ADJ : 9'h000);
    end

    // ----------------------------------------------------------------
    // result select; untouched flags and registers pass through
    // ----------------------------------------------------------------
    always_comb begin
        res_acc = acc;
        res_b = b;
        res_cy = cy;
        res_ov = ov;
        res_take = 1'b0;
        case (op)
            cfdp_pkg::CFDP_OP_DIV: begin
                res_cy = 1'b0;
                res_ov = (b == 8'h00);
                // divide by zero leaves both operands as they were
                if (b != 8'h00) begin
                    res_acc = acc / b;
                    res_b = acc % b;
                end
            end
            cfdp_pkg::CFDP_OP_DA: begin
                res_acc = sum_hi[7:0];
                res_cy = (sum_hi > `CFDP_DA_CY_LIMIT);
            end
            cfdp_pkg::CFDP_OP_RRC: begin
                res_acc = {cy, acc[7:1]};
                res_cy = acc[0];
            end
            cfdp_pkg::CFDP_OP_RLC: begin
                res_acc = {acc[6:0], cy};
                res_cy = acc[7];
            end
            cfdp_pkg::CFDP_OP_CJNE: begin
                res_take = (src != dst);
                res_cy = (src > dst);
            end
            default: begin
                res_take = 1'b0;
            end
        endcase
    end

endmodule

// *** verilog/cfdp_core.sv ***
// flag datapath for divide, decimal adjust, rotates, compare-and-branch,
// and the main and shadow data pointers with their control register
// assumes one sequencer on clk_sys drives all requests as one-cycle strobes
`include "cfdp_regs.svh"

module cfdp_core (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic op_valid,
    input wire cfdp_pkg::cfdp_op_type op_code,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] b_in,
    input wire logic cy_in,
    input wire logic aux_carry_flag,
    input wire logic overflow_flag,
    input wire logic [7:0] cmp_src,
    input wire logic [7:0] cmp_dst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic [7:0] sfr_wdata,
    input wire logic ptr_load_en,
    input wire logic [15:0] ptr_load_value,
    input wire logic ptr_move_en,
    input wire logic ptr_move_via_active_data_pointer,
    output logic [7:0] acc_out_ff,
    output logic [7:0] b_out_ff,
    output logic cy_out_ff,
    output logic ov_out_ff,
    output logic result_valid_ff,
    output logic branch_take_ff,
    output logic [7:0] sfr_rdata_ff,
    output logic [15:0] active_data_pointer_ff
);

    // ----------------------------------------------------------------
    // arithmetic results
    // ----------------------------------------------------------------
    cfdp_pkg::cfdp_op_type op_eff;
    logic [7:0] res_acc;
    logic [7:0] res_b;
    logic res_cy;
    logic res_ov;
    logic res_take;

    assign op_eff = op_valid ? op_code : cfdp_pkg::CFDP_OP_NONE;

    cfdp_arith u_arith (
        .op(op_eff),
        .acc(acc_in),
        .b(b_in),
        .cy(cy_in),
        .ac(aux_carry_flag),
        .ov(overflow_flag),
        .src(cmp_src),
        .dst(cmp_dst),
        .res_acc(res_acc),
        .res_b(res_b),
        .res_cy(res_cy),
        .res_ov(res_ov),
        .res_take(res_take)
    );

    logic [7:0] nxt_acc_out;
    logic [7:0] nxt_b_out;
    logic nxt_cy_out;
    logic nxt_ov_out;
    logic nxt_result_valid;
    logic nxt_branch_take;

    always_comb begin
        nxt_acc_out = acc_out_ff;
        nxt_b_out = b_out_ff;
        nxt_cy_out = cy_out_ff;
        nxt_ov_out = ov_out_ff;
        nxt_result_valid = 1'b0;
        nxt_branch_take = 1'b0;
        if (op_valid && op_code != cfdp_pkg::CFDP_OP_NONE) begin
            nxt_acc_out = res_acc;
            nxt_b_out = res_b;
            nxt_cy_out = res_cy;
            nxt_ov_out = res_ov;
            nxt_result_valid = 1'b1;
            nxt_branch_take = res_take;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_out_ff <= `CFDP_BYTE_RESET;
            b_out_ff <= `CFDP_BYTE_RESET;
            cy_out_ff <= 1'b0;
            ov_out_ff <= 1'b0;
            result_valid_ff <= 1'b0;
            branch_take_ff <= 1'b0;
        end else begin
            acc_out_ff <= nxt_acc_out;
            b_out_ff <= nxt_b_out;
            cy_out_ff <= nxt_cy_out;
            ov_out_ff <= nxt_ov_out;
            result_valid_ff <= nxt_result_valid;
            branch_take_ff <= nxt_branch_take;
        end
    end

    // ----------------------------------------------------------------
    // control register and pointers
    // ----------------------------------------------------------------
    logic [7:0] ctrl_ff;
    logic [15:0] main_ptr_ff;
    logic [15:0] shadow_ptr_ff;
    logic [7:0] nxt_ctrl;
    logic [15:0] nxt_main_ptr;
    logic [15:0] nxt_shadow_ptr;
    logic [15:0] nxt_active;
    logic [7:0] nxt_sfr_rdata;
    logic ctrl_hit;
    logic use_shadow;
    logic [15:0] used_ptr;
    logic [15:0] used_ptr_next;
    cfdp_pkg::cfdp_ptr_mode_type used_mode;

    assign ctrl_hit = (sfr_addr == `CFDP_CTRL_ADDR);
    assign use_shadow = ctrl_ff[`CFDP_CTRL_SEL_BIT];
    assign used_ptr = use_shadow ? shadow_ptr_ff : main_ptr_ff;
    assign used_mode = use_shadow ?
        cfdp_pkg::cfdp_ptr_mode_type'(ctrl_ff[`CFDP_CTRL_SHADOW_MODE_HI:`CFDP_CTRL_SHADOW_MODE_LO]) :
        cfdp_pkg::cfdp_ptr_mode_type'(ctrl_ff[`CFDP_CTRL_MAIN_MODE_HI:`CFDP_CTRL_MAIN_MODE_LO]);

    cfdp_ptr_step u_step (
        .ptr(used_ptr),
        .mode(used_mode),
        .ptr_next(used_ptr_next)
    );

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_main_ptr = main_ptr_ff;
        nxt_shadow_ptr = shadow_ptr_ff;
        // a load of the active pointer outranks the pointer step of a move in the same cycle
        if (ptr_load_en) begin
            if (use_shadow) begin
                nxt_shadow_ptr = ptr_load_value;
            end else begin
                nxt_main_ptr = ptr_load_value;
            end
        end else if (ptr_move_en && ptr_move_via_active_data_pointer) begin
            // step the pointer that was used, swap comes afterwards
            if (use_shadow) begin
                nxt_shadow_ptr = used_ptr_next;
            end else begin
                nxt_main_ptr = used_ptr_next;
            end
        end
        if (ptr_move_en && ctrl_ff[`CFDP_CTRL_SWAP_BIT]) begin
            nxt_ctrl[`CFDP_CTRL_SEL_BIT] = ~ctrl_ff[`CFDP_CTRL_SEL_BIT];
        end
        // software write wins over an automatic swap in the same cycle
        if (sfr_wr_en && ctrl_hit) begin
            nxt_ctrl = sfr_wdata & `CFDP_CTRL_WR_MASK;
        end
        nxt_active = nxt_ctrl[`CFDP_CTRL_SEL_BIT] ? nxt_shadow_ptr : nxt_main_ptr;
        nxt_sfr_rdata = (sfr_rd_en && ctrl_hit) ? ctrl_ff : 8'h00;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_ff <= `CFDP_CTRL_RESET;
            main_ptr_ff <= `CFDP_PTR_RESET;
            shadow_ptr_ff <= `CFDP_PTR_RESET;
            active_data_pointer_ff <= `CFDP_PTR_RESET;
            sfr_rdata_ff <= 8'h00;
        end else begin
            ctrl_ff <= nxt_ctrl;
            main_ptr_ff <= nxt_main_ptr;
            shadow_ptr_ff <= nxt_shadow_ptr;
            active_data_pointer_ff <= nxt_active;
            sfr_rdata_ff <= nxt_sfr_rdata;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking chk_cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    logic op_div;
    logic op_da;
    logic da_lo;
    logic [8:0] da_sum;
    logic mv_main_inc;

    assign op_div = op_valid && op_code == cfdp_pkg::CFDP_OP_DIV;
    assign op_da = op_valid && op_code == cfdp_pkg::CFDP_OP_DA;
    assign da_lo = aux_carry_flag || acc_in[3:0] > 4'h9;
    assign da_sum = {1'b0, acc_in} + (da_lo ? 9'h066 : (cy_in ? 9'h060 : 9'h000));
    assign mv_main_inc = ptr_move_en && ptr_move_via_active_data_pointer && !ptr_load_en && !use_shadow
        && ctrl_ff[3:2] == 2'b01;

    div_result_a: assert property (op_div && b_in != 8'h00 |=>
        acc_out_ff == $past(acc_in) / $past(b_in) && b_out_ff == $past(acc_in) % $past(b_in))
        else $error("divide result wrong");
    div_flags_a: assert property (op_div |=>
        !cy_out_ff && ov_out_ff == ($past(b_in) == 8'h00) && result_valid_ff)
        else $error("divide flags wrong");
    da_low_adj_a: assert property (op_da && da_lo |=>
        acc_out_ff == 8'($past(acc_in) + 8'h66))
        else $error("adjust low correction missing");
    da_high_adj_a: assert property (op_da && !da_lo |=>
        acc_out_ff == 8'($past(acc_in) + ($past(cy_in) ? 8'h60 : 8'h00)))
        else $error("adjust high correction wrong");
    da_carry_a: assert property (op_da |=> cy_out_ff == ($past(da_sum) > 9'h099))
        else $error("adjust carry wrong");
    rrc_rotate_a: assert property (op_valid && op_code == cfdp_pkg::CFDP_OP_RRC |=>
        {acc_out_ff, cy_out_ff} == {$past(cy_in), $past(acc_in)})
        else $error("rotate right wrong");
    rlc_rotate_a: assert property (op_valid && op_code == cfdp_pkg::CFDP_OP_RLC |=>
        {cy_out_ff, acc_out_ff} == {$past(acc_in), $past(cy_in)})
        else $error("rotate left wrong");
    cjne_branch_a: assert property (op_valid && op_code == cfdp_pkg::CFDP_OP_CJNE |=>
        branch_take_ff == ($past(cmp_src) != $past(cmp_dst)) ##1 !branch_take_ff || $past(op_valid))
        else $error("compare branch wrong");
    cjne_carry_a: assert property (op_valid && op_code == cfdp_pkg::CFDP_OP_CJNE |=>
        cy_out_ff == ($past(cmp_src) > $past(cmp_dst)))
        else $error("compare carry wrong");
    active_ptr_a: assert property (##1 active_data_pointer_ff ==
        (ctrl_ff[0] ? shadow_ptr_ff : main_ptr_ff))
        else $error("active pointer mismatch");
    load_active_a: assert property (ptr_load_en && !(sfr_wr_en && ctrl_hit) |=>
        active_data_pointer_ff == $past(ptr_load_value) || $past(ptr_move_en))
        else $error("load missed active pointer");
    other_move_a: assert property (ptr_move_en && !ptr_move_via_active_data_pointer && !ptr_load_en |=>
        $stable(main_ptr_ff) && $stable(shadow_ptr_ff))
        else $error("pointer changed by other move");
    auto_swap_a: assert property (ptr_move_en && !(sfr_wr_en && ctrl_hit) |=>
        ctrl_ff[0] == ($past(ctrl_ff[0]) ^ $past(ctrl_ff[6])))
        else $error("automatic swap wrong");
    bit7_zero_a: assert property (sfr_wr_en && ctrl_hit |=> !ctrl_ff[7] ##1 !sfr_rdata_ff[7])
        else $error("control bit 7 kept");
    main_inc_a: assert property (mv_main_inc |=>
        main_ptr_ff == 16'($past(main_ptr_ff) + 16'h0001) && $stable(shadow_ptr_ff))
        else $error("main pointer increment wrong");
    shadow_dec_a: assert property (ptr_move_en && ptr_move_via_active_data_pointer && !ptr_load_en && use_shadow
        && ctrl_ff[5:4] == 2'b10 |=>
        shadow_ptr_ff == 16'($past(shadow_ptr_ff) - 16'h0001))
        else $error("shadow pointer decrement wrong");

    // pass-through, register bus, main toggle and standard, and shadow increment pointer modes
    logic op_rot;
    logic op_cjne;
    logic mv_main;
    logic mv_shadow;
    assign op_rot = op_valid && (op_code == cfdp_pkg::CFDP_OP_RRC
        || op_code == cfdp_pkg::CFDP_OP_RLC);
    assign op_cjne = op_valid && op_code == cfdp_pkg::CFDP_OP_CJNE;
    assign mv_main = ptr_move_en && ptr_move_via_active_data_pointer && !ptr_load_en && !use_shadow;
    assign mv_shadow = ptr_move_en && ptr_move_via_active_data_pointer && !ptr_load_en && use_shadow;

    div_zero_keep_a: assert property (op_div && b_in == 8'h00 |=>
        acc_out_ff == $past(acc_in) && b_out_ff == $past(b_in))
        else $error("divide by zero changed operands");
    rot_keep_a: assert property (op_rot |=>
        b_out_ff == $past(b_in) && ov_out_ff == $past(overflow_flag))
        else $error("rotate touched b or overflow");
    cjne_keep_a: assert property (op_cjne |=>
        acc_out_ff == $past(acc_in) && b_out_ff == $past(b_in)
        && ov_out_ff == $past(overflow_flag))
        else $error("compare touched acc, b or overflow");
    idle_hold_a: assert property (!op_valid || op_code == cfdp_pkg::CFDP_OP_NONE |=>
        !result_valid_ff && !branch_take_ff && $stable(acc_out_ff) && $stable(cy_out_ff))
        else $error("idle cycle changed results");
    ctrl_write_a: assert property (sfr_wr_en && ctrl_hit |=>
        ctrl_ff == ($past(sfr_wdata) & `CFDP_CTRL_WR_MASK))
        else $error("control write wrong");
    ctrl_read_a: assert property (sfr_rd_en && ctrl_hit |=> sfr_rdata_ff == $past(ctrl_ff))
        else $error("control read wrong");
    foreign_read_a: assert property (!(sfr_rd_en && ctrl_hit) |=> sfr_rdata_ff == 8'h00)
        else $error("read data not cleared");
    no_swap_a: assert property (!ctrl_ff[6] && !(sfr_wr_en && ctrl_hit) |=>
        $stable(ctrl_ff))
        else $error("swap without enable");
    main_toggle_a: assert property (mv_main && ctrl_ff[3:2] == 2'b11 |=>
        main_ptr_ff == ($past(main_ptr_ff) ^ 16'h0001) && $stable(shadow_ptr_ff))
        else $error("main pointer toggle wrong");
    shadow_inc_a: assert property (mv_shadow && ctrl_ff[5:4] == 2'b01 |=>
        shadow_ptr_ff == 16'($past(shadow_ptr_ff) + 16'h0001) && $stable(main_ptr_ff))
        else $error("shadow pointer increment wrong");
    std_hold_a: assert property (mv_main && ctrl_ff[3:2] == 2'b00 |=> $stable(main_ptr_ff))
        else $error("standard mode moved pointer");

    div_zero_c: cover property (op_div && b_in == 8'h00);
    da_both_c: cover property (op_da && da_lo && cy_in);
    swap_move_c: cover property (ptr_move_en && ptr_move_via_active_data_pointer && ctrl_ff[6]);
    cjne_taken_c: cover property (op_valid && op_code == cfdp_pkg::CFDP_OP_CJNE ##1 branch_take_ff);

endmodule

// *** verilog/cfdp_pkg.sv ***
// types shared by the flag datapath and dual data pointer unit
// assumes nothing beyond a SystemVerilog compiler
package cfdp_pkg;

    // ----------------------------------------------------------------
    // operations handed over by the instruction sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CFDP_OP_NONE,
        CFDP_OP_DIV,
        CFDP_OP_DA,
        CFDP_OP_RRC,
        CFDP_OP_RLC,
        CFDP_OP_CJNE
    } cfdp_op_type;

    // ----------------------------------------------------------------
    // per pointer post-move update mode, order gives the field encoding
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CFDP_MODE_STANDARD,
        CFDP_MODE_INC,
        CFDP_MODE_DEC,
        CFDP_MODE_TOGGLE
    } cfdp_ptr_mode_type;

endpackage

// *** verilog/cfdp_ptr_step.sv ***
// post-move update of one 16-bit data pointer
// assumes the caller decides whether a move through the pointer happened
module cfdp_ptr_step (
    input wire logic [15:0] ptr,
    input wire cfdp_pkg::cfdp_ptr_mode_type mode,
    output logic [15:0] ptr_next
);

    // ----------------------------------------------------------------
    // step function, wraps modulo 2^16
    // ----------------------------------------------------------------
    function automatic logic [15:0] step(input logic [15:0] p,
                                         input cfdp_pkg::cfdp_ptr_mode_type m);
        logic [15:0] r;
        r = p;
        case (m)
            cfdp_pkg::CFDP_MODE_INC: r = 16'(p + 16'h0001);
            cfdp_pkg::CFDP_MODE_DEC: r = 16'(p - 16'h0001);
            cfdp_pkg::CFDP_MODE_TOGGLE: r = {p[15:1], ~p[0]};
            default: r = p;
        endcase
        return r;
    endfunction

    always_comb begin
        ptr_next = step(ptr, mode);
    end

endmodule

// *** verilog/cfdp_regs.svh ***
// constants of the flag datapath and dual data pointer unit
// assumes inclusion by bare name from every design file that needs them
`ifndef CFDP_REGS_SVH
`define CFDP_REGS_SVH

// ----------------------------------------------------------------
// data pointer control register
// ----------------------------------------------------------------
`define CFDP_CTRL_ADDR 8'hA7
`define CFDP_CTRL_RESET 8'h00
`define CFDP_CTRL_WR_MASK 8'h7D
`define CFDP_CTRL_SEL_BIT 0
`define CFDP_CTRL_SWAP_BIT 6
`define CFDP_CTRL_SHADOW_MODE_HI 5
`define CFDP_CTRL_SHADOW_MODE_LO 4
`define CFDP_CTRL_MAIN_MODE_HI 3
`define CFDP_CTRL_MAIN_MODE_LO 2

// ----------------------------------------------------------------
// reset values and arithmetic constants
// ----------------------------------------------------------------
`define CFDP_PTR_RESET 16'h0000
`define CFDP_BYTE_RESET 8'h00
`define CFDP_DA_LO_ADJ 9'h006
`define CFDP_DA_HI_ADJ 9'h060
`define CFDP_DA_LO_LIMIT 4'h9
`define CFDP_DA_CY_LIMIT 9'h099

`endif
